// ---- hw/umrw_top.sv ----
// Modem ring indicate, request-to-send and ring wake logic with Wishbone slave
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Status bit 6 reads the inverse of the ring-indicate pin level.
// - Status bit 2 sets when ring-indicate rose since last status read.
// - Ring flag set with modem status interrupts enabled raises channel interrupt.
// - With ring wake on, ring-indicate falling edge asserts power-on output.
// - Request-to-send driven low while control bit 1 is one.
// - Master reset drives request-to-send inactive high.
// - Loopback holds request-to-send inactive regardless of control bit.
// - Low pulse or pulse train on ring wake input asserts power-on output.
// - Power control register 2 field selects which pin is the ring input.
// - Power-on output is open-drain, pulled low to request supply on.
module umrw_top
  import umrw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Modem pins
  input wire logic ring_indicate_ch1_i,
  input wire logic ring_indicate_ch2_i,
  output logic rts_n_ch1_o,
  output logic rts_n_ch2_o,
  // Ring wake pins
  input wire logic ring_pin_a_i,
  input wire logic ring_pin_b_i,
  // Power-on control, open drain
  output logic power_on_control_out_o,
  output logic power_on_control_out_oe_o,
  // Interrupts
  output logic irq_ch1_o,
  output logic irq_ch2_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] ri_lvl;
  logic [1:0] ri_rise;
  logic [1:0] ri_fall;
  logic ring_a_fall;
  logic ring_b_fall;
  logic [1:0] ri_pins;

  assign ri_pins = {ring_indicate_ch2_i, ring_indicate_ch1_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ri
      umrw_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ri_pins[g]),
        .lvl_o(ri_lvl[g]),
        .rise_o(ri_rise[g]),
        .fall_o(ri_fall[g])
      );
    end
  endgenerate

  umrw_sync u_ring_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ring_pin_a_i),
    .lvl_o(),
    .rise_o(),
    .fall_o(ring_a_fall)
  );

  umrw_sync u_ring_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ring_pin_b_i),
    .lvl_o(),
    .rise_o(),
    .fall_o(ring_b_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    wr_byte = s[0] ? d[7:0] : old;
  endfunction

  logic acc;
  logic wr;
  logic rd;
  assign acc = cyc_i & stb_i & ~ack_o;
  assign wr = acc & we_i;
  assign rd = acc & ~we_i;

  logic [7:0] mcr_r [2];
  logic [7:0] pcr2_r;
  logic [1:0] ier_r;
  logic [2:0] ist_r;
  logic [2:0] imask_r;
  logic [1:0] trailing_edge_ring_flag_r;
  logic power_on_control_out_r;
  logic [1:0] msr_rd;

  assign msr_rd[0] = rd & (adr_i == OFS_MSR1);
  assign msr_rd[1] = rd & (adr_i == OFS_MSR2);

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcr_r[0] <= MCR_RST;
      mcr_r[1] <= MCR_RST;
      pcr2_r <= PCR2_RST;
      ier_r <= IER_RST;
      imask_r <= IMASK_RST;
    end else if (wr) begin
      case (adr_i)
        OFS_MCR1: begin
          mcr_r[0] <= wr_byte(mcr_r[0], dat_i, sel_i);
        end
        OFS_MCR2: begin
          mcr_r[1] <= wr_byte(mcr_r[1], dat_i, sel_i);
        end
        OFS_PCR2: begin
          pcr2_r <= wr_byte(pcr2_r, dat_i, sel_i) & 8'h07;
        end
        OFS_IER: begin
          if (sel_i[0]) begin
            ier_r <= dat_i[1:0];
          end
        end
        OFS_IMASK: begin
          if (sel_i[0]) begin
            imask_r <= dat_i[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trailing-edge ring flags
  generate
    for (g = 0; g < 2; g++) begin : g_trailing_edge_ring_flag
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          trailing_edge_ring_flag_r[g] <= 1'b0;
        // Set on rise, wins over clear
        end else if (ri_rise[g]) begin
          trailing_edge_ring_flag_r[g] <= 1'b1;
        end else if (msr_rd[g]) begin
          trailing_edge_ring_flag_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power-on control
  logic ring_sel_fall;
  logic wake_evt;
  assign ring_sel_fall = pcr2_r[PCR2_RING_SEL_BIT] ? ring_b_fall : ring_a_fall;
  // Gated ring-indicate falls; ring input pulses
  assign wake_evt = (pcr2_r[PCR2_RI_WAKE_BIT] & (|ri_fall)) |
                    (pcr2_r[PCR2_RING_WAKE_BIT] & ring_sel_fall);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_on_control_out_r <= 1'b0;
    end else if (wake_evt) begin
      power_on_control_out_r <= 1'b1;
    end else if (wr && adr_i == OFS_PCR2 && sel_i[0] && dat_i[PCR2_POWER_ON_CONTROL_OUT_CLR_BIT]) begin
      power_on_control_out_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_on_control_out_o <= 1'b0;
      power_on_control_out_oe_o <= 1'b0;
    end else begin
      power_on_control_out_o <= 1'b0;
      power_on_control_out_oe_o <= wake_evt | power_on_control_out_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request to send
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_n_ch1_o <= 1'b1;
      rts_n_ch2_o <= 1'b1;
    end else begin
      // Follows control bit, held off in loopback
      rts_n_ch1_o <= ~(mcr_r[0][MCR_RTS_BIT] & ~mcr_r[0][MCR_LOOP_BIT]);
      rts_n_ch2_o <= ~(mcr_r[1][MCR_RTS_BIT] & ~mcr_r[1][MCR_LOOP_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [2:0] ist_set;
  assign ist_set = {wake_evt, ri_rise};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_r <= 3'h0;
    end else if (wr && adr_i == OFS_ISTAT && sel_i[0]) begin
      ist_r <= (ist_r & ~dat_i[2:0]) | ist_set;
    end else begin
      ist_r <= ist_r | ist_set;
    end
  end

  logic [1:0] trailing_edge_ring_flag_nxt;
  assign trailing_edge_ring_flag_nxt = (trailing_edge_ring_flag_r | ri_rise) & ~(msr_rd & ~ri_rise);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ch1_o <= 1'b0;
      irq_ch2_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_ch1_o <= trailing_edge_ring_flag_nxt[0] & ier_r[0];
      irq_ch2_o <= trailing_edge_ring_flag_nxt[1] & ier_r[1];
      irq_o <= |(ist_r & imask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge
  logic [31:0] rdata;
  always_comb begin
    rdata = RD_UNMAPPED;
    case (adr_i)
      OFS_MCR1: rdata[7:0] = mcr_r[0];
      OFS_MCR2: rdata[7:0] = mcr_r[1];
      OFS_MSR1: begin
        rdata[MSR_RI_BIT] = ~ri_lvl[0];
        rdata[MSR_TRAILING_EDGE_RING_FLAG_BIT] = trailing_edge_ring_flag_r[0];
      end
      OFS_MSR2: begin
        rdata[MSR_RI_BIT] = ~ri_lvl[1];
        rdata[MSR_TRAILING_EDGE_RING_FLAG_BIT] = trailing_edge_ring_flag_r[1];
      end
      OFS_PCR2: rdata[7:0] = {pcr2_r[7:4], power_on_control_out_r, pcr2_r[2:0]};
      OFS_IER: rdata[1:0] = ier_r;
      OFS_ISTAT: rdata[2:0] = ist_r;
      OFS_IMASK: rdata[2:0] = imask_r;
      default: rdata = RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= acc;
      dat_o <= rd ? rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_ri_inv;
    @(posedge clk_i) disable iff (rst_i)
      (rd && adr_i == OFS_MSR1) |=> (dat_o[MSR_RI_BIT] == ~$past(ri_lvl[0]));
  endproperty
  a_ri_inv: assert property (p_ri_inv) else $error("ring bit not inverse");

  property p_trailing_edge_ring_flag_set;
    @(posedge clk_i) disable iff (rst_i) ri_rise[0] |=> trailing_edge_ring_flag_r[0];
  endproperty
  a_trailing_edge_ring_flag_set: assert property (p_trailing_edge_ring_flag_set) else $error("ring flag not set");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      (trailing_edge_ring_flag_r[0] && ier_r[0] && !msr_rd[0]) |=> irq_ch1_o;
  endproperty
  a_irq: assert property (p_irq) else $error("channel irq missing");

  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
      (pcr2_r[PCR2_RI_WAKE_BIT] && ri_fall[1]) |=> power_on_control_out_oe_o;
  endproperty
  a_wake: assert property (p_wake) else $error("ring wake failed");

  property p_rts;
    @(posedge clk_i) disable iff (rst_i)
      (mcr_r[0][MCR_RTS_BIT] && !mcr_r[0][MCR_LOOP_BIT]) |=> !rts_n_ch1_o;
  endproperty
  a_rts: assert property (p_rts) else $error("rts not active");

  property p_rts_rst;
    @(posedge clk_i) rst_i |=> (rts_n_ch1_o && rts_n_ch2_o);
  endproperty
  a_rts_rst: assert property (p_rts_rst) else $error("rts active after reset");

  property p_loop;
    @(posedge clk_i) disable iff (rst_i) mcr_r[1][MCR_LOOP_BIT] |=> rts_n_ch2_o;
  endproperty
  a_loop: assert property (p_loop) else $error("rts active in loopback");

  property p_ring;
    @(posedge clk_i) disable iff (rst_i)
      (pcr2_r[PCR2_RING_WAKE_BIT] && ring_sel_fall) |=> power_on_control_out_r [*2];
  endproperty
  a_ring: assert property (p_ring) else $error("ring pin wake failed");

  property p_clr;
    @(posedge clk_i) disable iff (rst_i)
      (msr_rd[0] && !ri_rise[0]) |=> !trailing_edge_ring_flag_r[0];
  endproperty
  a_clr: assert property (p_clr) else $error("ring flag not cleared");

  property p_od;
    @(posedge clk_i) disable iff (rst_i) !power_on_control_out_o;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");

  property p_wake_off;
    @(posedge clk_i) disable iff (rst_i)
      (!pcr2_r[PCR2_RI_WAKE_BIT] && !pcr2_r[PCR2_RING_WAKE_BIT] && !power_on_control_out_r)
        |=> !power_on_control_out_oe_o;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("power-on without enable");

endmodule
`default_nettype wire

// ---- include/umrw_pkg.sv ----
// Package: register map, field positions and reset values for the modem ring/wake block
package umrw_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_MCR1 = 5'h00;
  localparam logic [4:0] OFS_MSR1 = 5'h04;
  localparam logic [4:0] OFS_MCR2 = 5'h08;
  localparam logic [4:0] OFS_MSR2 = 5'h0C;
  localparam logic [4:0] OFS_PCR2 = 5'h10;
  localparam logic [4:0] OFS_IER = 5'h14;
  localparam logic [4:0] OFS_ISTAT = 5'h18;
  localparam logic [4:0] OFS_IMASK = 5'h1C;
  // Modem control fields
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_LOOP_BIT = 4;
  // Modem status fields
  localparam int MSR_TRAILING_EDGE_RING_FLAG_BIT = 2;
  localparam int MSR_RI_BIT = 6;
  // Power control 2 fields
  localparam int PCR2_RING_SEL_BIT = 0;
  localparam int PCR2_RI_WAKE_BIT = 1;
  localparam int PCR2_RING_WAKE_BIT = 2;
  localparam int PCR2_POWER_ON_CONTROL_OUT_CLR_BIT = 3;
  // Interrupt status fields
  localparam int IST_CH1_BIT = 0;
  localparam int IST_CH2_BIT = 1;
  localparam int IST_WAKE_BIT = 2;
  // Reset values
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] PCR2_RST = 8'h00;
  localparam logic [1:0] IER_RST = 2'h0;
  localparam logic [2:0] IMASK_RST = 3'h0;
  // Unmapped read value
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ---- hw/umrw_sync.sv ----
// Two-flop synchroniser with edge outputs taken after the second flop
`timescale 1ns/100ps
`default_nettype none
module umrw_sync
  import umrw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous pin
  input wire logic pin_i,
  // Synchronised level and edges
  output logic lvl_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign lvl_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;
endmodule
`default_nettype wire

// ---- test/umrw_modem.sv ----
// Line-side model: modem ring lines and ring wake pulse source
`timescale 1ns/100ps
`default_nettype none
module umrw_modem (
  // Clock
  input wire logic clk_i,
  // Commands from the bench
  input wire logic [1:0] ring_i,
  input wire logic [1:0] pulse_i,
  // Line-side pins, idle high
  output logic [1:0] ri_o,
  output logic [1:0] pin_o
);
  logic [1:0] tog_r = 2'h0;
  assign ri_o = ~ring_i;
  // Pulse train toggler
  always @(posedge clk_i) begin
    tog_r <= pulse_i & ~tog_r;
  end
  assign pin_o = ~(pulse_i & tog_r);
endmodule
`default_nettype wire

// ---- test/tb_umrw_top.sv ----
// Self-checking testbench for the modem ring/wake block
`timescale 1ns/100ps
`default_nettype none
module tb_umrw_top;
  import umrw_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [1:0] ring = 2'h0;
  logic [1:0] pls = 2'h0;
  logic [1:0] ri, pin, rts_n;
  logic [31:0] dat_o;
  logic ack_o, oe, od, irq1, irq2, irq;
  logic [31:0] expq[$];
  logic [7:0] v;
  logic [4:0] a;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  umrw_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .ring_indicate_ch1_i(ri[0]), .ring_indicate_ch2_i(ri[1]), .rts_n_ch1_o(rts_n[0]),
    .rts_n_ch2_o(rts_n[1]), .ring_pin_a_i(pin[0]), .ring_pin_b_i(pin[1]),
    .power_on_control_out_o(od), .power_on_control_out_oe_o(oe), .irq_ch1_o(irq1),
    .irq_ch2_o(irq2), .irq_o(irq));
  umrw_modem mdm (.clk_i(clk_i), .ring_i(ring), .pulse_i(pls), .ri_o(ri), .pin_o(pin));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single cycle, release at ack edge, one idle cycle
  task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] d,
                     input logic [7:0] e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= 4'h1;
    dat <= {24'h0, d};
    if (!w) expq.push_back({24'h0, e});
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    bus(1'b1, ad, d, 8'h00);
  endtask

  task automatic rd(input logic [4:0] ad, input logic [7:0] e);
    bus(1'b0, ad, 8'h00, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Read data checker, oldest note first
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) begin
        cmp(dat_o, 32'hFFFF_FFFF);
      end else begin
        cmp(dat_o, expq.pop_front());
      end
    end
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    v = 8'($urandom(32'h9E1FED5A));
    wait_cyc(20);
    rst_i <= 1'b0;
    wait_cyc(2);
    cmp({30'h0, rts_n}, 32'h3);
    cmp({29'h0, oe, od, irq}, 32'h0);
    rd(OFS_PCR2, 8'h00);
    wr(5'h02, 8'hFF);
    rd(5'h02, 8'h00);
    rd(OFS_MCR1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? {3'h0, i[1], 2'h0, i[0], 1'h0} : (8'($urandom) & 8'h12);
      wr(OFS_MCR1, v);
      wr(OFS_MCR2, ~v & 8'h12);
      wait_cyc(2);
      cmp({31'h0, rts_n[0]}, {31'h0, ~(v[1] & ~v[4])});
      cmp({31'h0, rts_n[1]}, {31'h0, ~(~v[1] & v[4])});
      rd(OFS_MCR1, v);
    end
    for (int c = 0; c < 2; c++) begin
      a = c ? OFS_MSR2 : OFS_MSR1;
      ring[c] <= 1'b1;
      wait_cyc(6);
      rd(a, 8'h40);
      ring[c] <= 1'b0;
      wait_cyc(6);
      rd(a, 8'h04);
      rd(a, 8'h00);
      cmp({31'h0, oe}, 32'h0);
    end
    wr(OFS_ISTAT, 8'h07);
    wr(OFS_IER, 8'h01);
    wr(OFS_IMASK, 8'h00);
    ring[0] <= 1'b1;
    wait_cyc(4);
    ring[0] <= 1'b0;
    wait_cyc(8);
    cmp({29'h0, irq1, irq2, irq}, 32'h4);
    rd(OFS_ISTAT, 8'h01);
    wr(OFS_IMASK, 8'h01);
    wait_cyc(3);
    cmp({31'h0, irq}, 32'h1);
    rd(OFS_MSR1, 8'h04);
    wait_cyc(3);
    cmp({31'h0, irq1}, 32'h0);
    wr(OFS_ISTAT, 8'h01);
    wait_cyc(3);
    cmp({31'h0, irq}, 32'h0);
    wr(OFS_IER, 8'h02);
    wr(OFS_PCR2, 8'h02);
    ring[1] <= 1'b1;
    wait_cyc(6);
    cmp({30'h0, oe, od}, 32'h2);
    ring[1] <= 1'b0;
    wait_cyc(6);
    cmp({31'h0, irq2}, 32'h1);
    rd(OFS_PCR2, 8'h0A);
    rd(OFS_MSR2, 8'h04);
    wr(OFS_PCR2, 8'h0A);
    wait_cyc(3);
    cmp({31'h0, oe}, 32'h0);
    cmp({31'h0, irq2}, 32'h0);
    wr(OFS_ISTAT, 8'h07);
    wr(OFS_IMASK, 8'h04);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_PCR2, (k == 2) ? 8'h05 : 8'h04);
      pls <= (k == 1) ? 2'b01 : 2'b10;
      wait_cyc(8);
      pls <= 2'b00;
      wait_cyc(5);
      cmp({31'h0, oe}, {31'h0, (k != 0)});
      wr(OFS_PCR2, 8'h0C);
    end
    wait_cyc(3);
    cmp({31'h0, irq}, 32'h1);
    rd(OFS_ISTAT, 8'h04);
    wait_cyc(4);
    summarize();
  end
endmodule
`default_nettype wire
